// [core/cpm_pkg.sv]
// Purpose: Shared constants and types for the console port mode controller
// Assumes: Byte-wide character streams on one 50 MHz clock
// Notes:   Codes, counts and the baud reset value live here
package cpm_pkg;

    // Character stream width, queue depth and synchroniser width
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W     = 6;

    // Clock rate, kept for time-to-cycle conversions
    localparam int CLK_HZ = 50_000_000;

    // Cycles the strap synchronisers need before the jumpers are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Characters that the controller recognises or emits
    localparam logic [7:0] CHR_AT    = 8'h40;
    localparam logic [7:0] CHR_C     = 8'h43;
    localparam logic [7:0] CHR_P     = 8'h50;
    localparam logic [7:0] CHR_CR    = 8'h0D;
    localparam logic [7:0] CHR_LF    = 8'h0A;
    localparam logic [7:0] CHR_SLASH = 8'h2F;

    // Length of the fixed texts and of an at-sign run
    localparam logic [1:0] TEXT_LEN = 2'h2;
    localparam logic [1:0] AT_ONE   = 2'h1;
    localparam logic [1:0] AT_TWO   = 2'h2;

    // Reset values
    localparam logic [3:0] BAUD_RST = 4'h0;

    // Port modes
    typedef enum logic {
        CPM_MODE_PANEL   = 1'b0,
        CPM_MODE_CONSOLE = 1'b1
    } cpm_mode_t;

    // Escape matcher states, Gray coded along idle-at-at-letter
    typedef enum logic [1:0] {
        CPM_ESC_IDLE = 2'b00,
        CPM_ESC_AT1  = 2'b01,
        CPM_ESC_AT2  = 2'b11,
        CPM_ESC_LET  = 2'b10
    } cpm_esc_t;

    // One character with its strobe
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } cpm_byte_t;

    // True for the letters that pick the mode in a mode-switch escape
    function automatic logic cpm_is_esc_letter(input logic [7:0] c);
        return (c == CHR_C) || (c == CHR_P);
    endfunction

endpackage

// [core/cpm_sync.sv]
// Purpose: Three-stage synchroniser for pins entering the clock domain
// Assumes: Inputs are slow levels from jumpers or the CPU panel lines
// Notes:   Stage one feeds stage two only; callers compare stages two and three
`timescale 1ns/100ps
module cpm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] mid_o,
    output logic      [WIDTH-1:0] last_o
);

    logic [WIDTH-1:0] first;

    // Shift chain, cleared at reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first  <= '0;
            mid_o  <= '0;
            last_o <= '0;
        end else begin
            first  <= pin_i;
            mid_o  <= first;
            last_o <= mid_o;
        end
    end

endmodule

// [core/cpm_fifo.sv]
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock; full and empty are registered
// Notes:   Holds console-bound software output while the port is in panel mode
`timescale 1ns/100ps
module cpm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Pointer and occupancy update
    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    // Registered pointers and flags
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            in_ready_o  <= (next_count != (AW+1)'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule

// [core/cpm_console_port.sv]
// Purpose: Mode controller for the console serial port (panel / console)
// Assumes: UART byte streams on clock_i; rx bytes at least 6 cycles apart
// Notes:   Straps and CPU halt line arrive from pins through synchronisers
`timescale 1ns/100ps
module cpm_console_port (
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    input  wire logic               panel_en_i,
    input  wire logic [3:0]         baud_jmp_i,
    input  wire logic               cpu_halt_n_i,
    input  wire logic               rx_valid_i,
    input  wire logic [7:0]         rx_data_i,
    output cpm_pkg::cpm_byte_t      tx_o,
    input  wire logic               tx_ready_i,
    input  wire logic               sw_tx_valid_i,
    input  wire logic [7:0]         sw_tx_data_i,
    output logic                    sw_tx_ready_o,
    output cpm_pkg::cpm_byte_t      sw_rx_o,
    output cpm_pkg::cpm_byte_t      cmd_o,
    input  wire logic               pnl_tx_valid_i,
    input  wire logic [7:0]         pnl_tx_data_i,
    output logic                    pnl_ack_o,
    input  wire logic               prompt_req_i,
    input  wire logic               run_cmd_i,
    input  wire logic               disconnect_i,
    output logic                    cpu_run_o,
    output logic                    status_req_o,
    output logic                    mode_console_o,
    output logic                    panel_active_o,
    output logic                    dtr_o,
    output logic [3:0]              baud_sel_o
);

    // Synchronised pins
    logic [cpm_pkg::SYNC_W-1:0] pin_mid;
    logic [cpm_pkg::SYNC_W-1:0] pin_last;

    // Registered state
    logic [1:0]           strap_cnt;
    logic                 strap_done;
    logic                 panel_en_q;
    logic                 halted;
    cpm_pkg::cpm_mode_t   mode;
    cpm_pkg::cpm_esc_t    esc_state;
    logic [7:0]           esc_let;
    logic [1:0]           rep_at;
    logic                 rep_let_v;
    logic [7:0]           rep_let;
    logic                 rep_chr_v;
    logic [7:0]           rep_chr;
    logic                 echo_v;
    logic [7:0]           echo_d;
    logic [1:0]           crlf_left;
    logic [1:0]           prompt_left;

    // Next values
    logic [1:0]           next_strap_cnt;
    logic                 next_strap_done;
    logic                 next_panel_en_q;
    logic [3:0]           next_baud_sel;
    logic                 next_halted;
    cpm_pkg::cpm_mode_t   next_mode;
    cpm_pkg::cpm_esc_t    next_esc_state;
    logic [7:0]           next_esc_let;
    logic [1:0]           next_rep_at;
    logic                 next_rep_let_v;
    logic [7:0]           next_rep_let;
    logic                 next_rep_chr_v;
    logic [7:0]           next_rep_chr;
    logic                 next_echo_v;
    logic [7:0]           next_echo_d;
    logic [1:0]           next_crlf_left;
    logic [1:0]           next_prompt_left;
    cpm_pkg::cpm_byte_t   next_tx;
    cpm_pkg::cpm_byte_t   next_sw_rx;
    cpm_pkg::cpm_byte_t   next_cmd;
    logic                 next_pnl_ack;
    logic                 next_cpu_run;
    logic                 next_status_req;
    logic                 next_dtr;

    // Queue toward the serial side
    logic                 q_valid;
    logic [7:0]           q_data;
    logic                 q_pop;

    // Decoded conditions
    logic                 active;
    logic                 halt_stable;
    logic                 halt_event;
    logic                 rx_take;
    logic                 esc_hit;
    logic                 fwd;
    logic [1:0]           rep_n;
    logic                 rep_lv;
    logic                 rep_cv;

    // Straps and the halt line come from pins
    cpm_sync #(
        .WIDTH(cpm_pkg::SYNC_W)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .pin_i  ({~cpu_halt_n_i, panel_en_i, baud_jmp_i}),
        .mid_o  (pin_mid),
        .last_o (pin_last)
    );

    // Software output waits here until console mode, or a clear enable strap, drains it
    cpm_fifo #(
        .WIDTH(cpm_pkg::DATA_W),
        .DEPTH(cpm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .in_valid_i (sw_tx_valid_i),
        .in_data_i  (sw_tx_data_i),
        .in_ready_o (sw_tx_ready_o),
        .out_valid_o(q_valid),
        .out_data_o (q_data),
        .out_ready_i(q_pop)
    );

    // Panel duty only once straps are caught and the enable strap is set
    assign active      = strap_done && panel_en_q;
    assign halt_stable = (pin_mid[5] == pin_last[5]);
    assign halt_event  = active && !halted && halt_stable && pin_last[5];
    assign rx_take     = rx_valid_i && strap_done;

    // Escape matcher: decides forwarding, replay of held characters and hits
    always_comb begin
        next_esc_state = esc_state;
        next_esc_let   = esc_let;
        esc_hit        = 1'b0;
        fwd            = 1'b0;
        rep_n          = 2'h0;
        rep_lv         = 1'b0;
        rep_cv         = 1'b0;
        if (rx_take && active) begin
            unique case (esc_state)
                cpm_pkg::CPM_ESC_IDLE: begin
                    if (rx_data_i == cpm_pkg::CHR_AT) begin
                        next_esc_state = cpm_pkg::CPM_ESC_AT1;
                    end else begin
                        fwd = 1'b1;
                    end
                end
                cpm_pkg::CPM_ESC_AT1: begin
                    if (rx_data_i == cpm_pkg::CHR_AT) begin
                        next_esc_state = cpm_pkg::CPM_ESC_AT2;
                    end else begin
                        rep_n          = cpm_pkg::AT_ONE;
                        rep_cv         = 1'b1;
                        next_esc_state = cpm_pkg::CPM_ESC_IDLE;
                    end
                end
                cpm_pkg::CPM_ESC_AT2: begin
                    if (rx_data_i == cpm_pkg::CHR_AT) begin
                        rep_n = cpm_pkg::AT_ONE;                         // Oldest @ is plain
                    end else if (cpm_pkg::cpm_is_esc_letter(rx_data_i)) begin
                        next_esc_let   = rx_data_i;
                        next_esc_state = cpm_pkg::CPM_ESC_LET;
                    end else begin
                        rep_n          = cpm_pkg::AT_TWO;
                        rep_cv         = 1'b1;
                        next_esc_state = cpm_pkg::CPM_ESC_IDLE;
                    end
                end
                cpm_pkg::CPM_ESC_LET: begin
                    if (rx_data_i == cpm_pkg::CHR_CR) begin
                        esc_hit        = 1'b1;
                        next_esc_state = cpm_pkg::CPM_ESC_IDLE;
                    end else if (rx_data_i == cpm_pkg::CHR_AT) begin
                        rep_n          = cpm_pkg::AT_TWO;
                        rep_lv         = 1'b1;
                        next_esc_state = cpm_pkg::CPM_ESC_AT1;
                    end else begin
                        rep_n          = cpm_pkg::AT_TWO;
                        rep_lv         = 1'b1;
                        rep_cv         = 1'b1;
                        next_esc_state = cpm_pkg::CPM_ESC_IDLE;
                    end
                end
            endcase
        end
    end

    // Mode, output arbitration, echo, prompts and CPU handshakes
    always_comb begin
        next_strap_cnt   = strap_cnt;
        next_strap_done  = strap_done;
        next_panel_en_q  = panel_en_q;
        next_baud_sel    = baud_sel_o;
        next_halted      = halted;
        next_mode        = mode;
        next_rep_at      = rep_at;
        next_rep_let_v   = rep_let_v;
        next_rep_let     = rep_let;
        next_rep_chr_v   = rep_chr_v;
        next_rep_chr     = rep_chr;
        next_echo_v      = echo_v;
        next_echo_d      = echo_d;
        next_crlf_left   = crlf_left;
        next_prompt_left = prompt_left;
        next_tx          = tx_o;
        next_sw_rx       = '0;
        next_cmd         = '0;
        next_pnl_ack     = 1'b0;
        next_cpu_run     = 1'b0;
        next_status_req  = 1'b0;
        next_dtr         = dtr_o;
        q_pop            = 1'b0;

        // Catch straps once the synchronisers have settled
        if (!strap_done) begin
            next_strap_cnt = 2'(strap_cnt + 1'b1);
            if (strap_cnt == cpm_pkg::STRAP_SETTLE) begin
                next_strap_done = 1'b1;
                next_panel_en_q = pin_last[4];
                next_baud_sel   = pin_last[3:0];
                next_mode       = cpm_pkg::CPM_MODE_PANEL;
                if (pin_last[4]) begin
                    next_prompt_left = cpm_pkg::TEXT_LEN;
                end
            end
        end

        // Halt line counts once two stages agree
        if (halt_stable) begin
            next_halted = pin_last[5];
        end

        // Serial output: one source per character, fixed priority
        if (!tx_o.valid || tx_ready_i) begin
            next_tx.valid = 1'b0;
            if (echo_v) begin
                next_tx     = '{valid: 1'b1, data: echo_d};
                next_echo_v = 1'b0;
            end else if (crlf_left != 2'h0) begin
                next_tx.valid  = 1'b1;
                next_tx.data   = (crlf_left == cpm_pkg::TEXT_LEN) ? cpm_pkg::CHR_CR
                                                                  : cpm_pkg::CHR_LF;
                next_crlf_left = 2'(crlf_left - 1'b1);
            end else if (prompt_left != 2'h0 && mode == cpm_pkg::CPM_MODE_PANEL) begin
                next_tx          = '{valid: 1'b1, data: cpm_pkg::CHR_SLASH};
                next_prompt_left = 2'(prompt_left - 1'b1);
            end else if (pnl_tx_valid_i && active
                         && mode == cpm_pkg::CPM_MODE_PANEL) begin
                next_tx      = '{valid: 1'b1, data: pnl_tx_data_i};
                next_pnl_ack = 1'b1;
            end else if (q_valid && strap_done
                         && (!panel_en_q || mode == cpm_pkg::CPM_MODE_CONSOLE)) begin
                next_tx = '{valid: 1'b1, data: q_data};
                q_pop   = 1'b1;
            end
        end

        // Replay characters held back by a broken escape, one per cycle
        if (rep_at != 2'h0) begin
            next_sw_rx  = '{valid: 1'b1, data: cpm_pkg::CHR_AT};
            next_rep_at = 2'(rep_at - 1'b1);
        end else if (rep_let_v) begin
            next_sw_rx     = '{valid: 1'b1, data: rep_let};
            next_rep_let_v = 1'b0;
        end else if (rep_chr_v) begin
            next_sw_rx     = '{valid: 1'b1, data: rep_chr};
            next_rep_chr_v = 1'b0;
        end

        // Received characters
        if (rx_take && !panel_en_q) begin
            next_sw_rx = '{valid: 1'b1, data: rx_data_i};
        end else if (rx_take && mode == cpm_pkg::CPM_MODE_PANEL) begin
            // Panel keys go to the command interpreter; lock and power keys are not decoded
            next_cmd = '{valid: 1'b1, data: rx_data_i};
            if (!esc_hit) begin
                next_echo_v = 1'b1;
                next_echo_d = rx_data_i;
            end
        end else if (rx_take) begin
            // Console keys pass through unless part of an escape
            if (fwd) begin
                next_sw_rx = '{valid: 1'b1, data: rx_data_i};
            end
            next_rep_at    = rep_n;
            next_rep_let_v = rep_lv;
            next_rep_let   = esc_let;
            next_rep_chr_v = rep_cv;
            next_rep_chr   = rx_data_i;
        end

        // Completed escape switches the mode
        if (esc_hit) begin
            next_crlf_left = cpm_pkg::TEXT_LEN;
            if (esc_let == cpm_pkg::CHR_C) begin
                next_mode        = cpm_pkg::CPM_MODE_CONSOLE;
                next_prompt_left = 2'h0;
            end else begin
                next_mode        = cpm_pkg::CPM_MODE_PANEL;
                next_prompt_left = cpm_pkg::TEXT_LEN;
            end
        end

        // Panel firmware asks for the next prompt
        if (prompt_req_i && active && next_mode == cpm_pkg::CPM_MODE_PANEL) begin
            next_prompt_left = cpm_pkg::TEXT_LEN;
        end

        // Accepted run command hands the port to software
        if (run_cmd_i && active && mode == cpm_pkg::CPM_MODE_PANEL) begin
            next_mode        = cpm_pkg::CPM_MODE_CONSOLE;
            next_prompt_left = 2'h0;
            next_cpu_run     = halted;
        end

        // Run-to-halt takes the port back for the operator; wins over the rest
        if (halt_event) begin
            next_mode       = cpm_pkg::CPM_MODE_PANEL;
            next_status_req = 1'b1;
        end

        // Terminal-ready drops only on disconnect
        if (disconnect_i) begin
            next_dtr = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_cnt      <= 2'h0;
            strap_done     <= 1'b0;
            panel_en_q     <= 1'b0;
            baud_sel_o     <= cpm_pkg::BAUD_RST;
            halted         <= 1'b0;
            mode           <= cpm_pkg::CPM_MODE_PANEL;
            esc_state      <= cpm_pkg::CPM_ESC_IDLE;
            esc_let        <= 8'h00;
            rep_at         <= 2'h0;
            rep_let_v      <= 1'b0;
            rep_let        <= 8'h00;
            rep_chr_v      <= 1'b0;
            rep_chr        <= 8'h00;
            echo_v         <= 1'b0;
            echo_d         <= 8'h00;
            crlf_left      <= 2'h0;
            prompt_left    <= 2'h0;
            tx_o           <= '0;
            sw_rx_o        <= '0;
            cmd_o          <= '0;
            pnl_ack_o      <= 1'b0;
            cpu_run_o      <= 1'b0;
            status_req_o   <= 1'b0;
            dtr_o          <= 1'b1;
            mode_console_o <= 1'b0;
            panel_active_o <= 1'b0;
        end else begin
            strap_cnt      <= next_strap_cnt;
            strap_done     <= next_strap_done;
            panel_en_q     <= next_panel_en_q;
            baud_sel_o     <= next_baud_sel;
            halted         <= next_halted;
            mode           <= next_mode;
            esc_state      <= next_esc_state;
            esc_let        <= next_esc_let;
            rep_at         <= next_rep_at;
            rep_let_v      <= next_rep_let_v;
            rep_let        <= next_rep_let;
            rep_chr_v      <= next_rep_chr_v;
            rep_chr        <= next_rep_chr;
            echo_v         <= next_echo_v;
            echo_d         <= next_echo_d;
            crlf_left      <= next_crlf_left;
            prompt_left    <= next_prompt_left;
            tx_o           <= next_tx;
            sw_rx_o        <= next_sw_rx;
            cmd_o          <= next_cmd;
            pnl_ack_o      <= next_pnl_ack;
            cpu_run_o      <= next_cpu_run;
            status_req_o   <= next_status_req;
            dtr_o          <= next_dtr;
            mode_console_o <= (next_mode == cpm_pkg::CPM_MODE_CONSOLE) && next_panel_en_q;
            panel_active_o <= next_strap_done && next_panel_en_q;
        end
    end

endmodule

// [dv/cpm_term.sv]
// Purpose: Operator terminal model facing the console port streams
// Assumes: Keys at least 8 cycles apart
// Notes:   Sink stalls at random while slow_i is high
`timescale 1ns/100ps
module cpm_term (
    input  wire logic       clock_i,
    input  wire logic       slow_i,
    output logic            ready_o,
    output logic            key_valid_o,
    output logic [7:0]      key_data_o
);
    // Idle lines at time zero
    initial begin
        {ready_o, key_valid_o, key_data_o} = '0;
    end
    // Sink readiness, random stalls when slow
    always @(negedge clock_i) ready_o <= slow_i ? 1'($urandom % 2) : 1'b1;
    // One keystroke strobe, then a quiet gap with the line toggled
    task automatic key(input logic [7:0] c);
        @(negedge clock_i);
        key_data_o = c;
        key_valid_o = 1'b1;
        @(negedge clock_i);
        key_valid_o = 1'b0;
        key_data_o = ~c;
        repeat (6) @(negedge clock_i);
    endtask
endmodule

// [dv/cpm_console_port_monitor.sv]
// Purpose: Port-level checks of the console port mode controller
// Assumes: Halt line steady six cycles means no halt event pending
// Notes:   Bound into the controller below
`timescale 1ns/100ps
module cpm_mon (
    input wire logic clock_i, rst_n_i, cpu_halt_n_i, rx_valid_i, tx_ready_i,
    input wire logic run_cmd_i, disconnect_i, cpu_run_o, status_req_o,
    input wire logic mode_console_o, panel_active_o, dtr_o,
    input wire logic [7:0] rx_data_i,
    input cpm_pkg::cpm_byte_t tx_o, sw_rx_o, cmd_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Key in panel mode; run request in panel mode
    sequence s_pkey; rx_valid_i && panel_active_o && !mode_console_o; endsequence
    sequence s_run; run_cmd_i && panel_active_o && !mode_console_o; endsequence
    a_tx_hold: assert property (tx_o.valid && !tx_ready_i |=> $stable(tx_o))
        else $error("tx byte changed before taken");
    a_key_cmd: assert property (s_pkey |=> cmd_o.valid && cmd_o.data == $past(rx_data_i))
        else $error("panel key not passed on");
    a_console_quiet: assert property (rx_valid_i && mode_console_o |=> !cmd_o.valid)
        else $error("console key reached panel");
    a_escape_eaten: assert property (rx_valid_i && mode_console_o && rx_data_i == 8'h40
        |=> !sw_rx_o.valid)
        else $error("escape byte forwarded");
    a_run_enter: assert property (cpu_halt_n_i [*6] ##0 s_run |=> mode_console_o && !cpu_run_o)
        else $error("run left port in panel");
    a_run_cpu: assert property (!cpu_halt_n_i [*6] ##0 s_run |=> cpu_run_o && mode_console_o)
        else $error("halted cpu not started");
    a_strap_off: assert property (!panel_active_o |-> !mode_console_o)
        else $error("switching without panel duty");
    a_dtr_drop: assert property (disconnect_i |=> !dtr_o)
        else $error("ready line kept after disconnect");
    a_dtr_held: assert property ($fell(dtr_o) |-> $past(disconnect_i))
        else $error("ready line dropped unasked");
    a_halt_panel: assert property (status_req_o |-> !mode_console_o)
        else $error("status shown outside panel");
endmodule
bind cpm_console_port cpm_mon u_cpm_mon (.*);

// [dv/tb_cpm_console_port.sv]
// Purpose: Self-checking bench of the console port mode controller
// Assumes: Terminal model answers keys and sinks tx bytes
// Notes:   Notes per stream: 0 tx, 1 software rx, 2 command
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module tb_cpm_console_port;
    logic clock_i, rst_n_i, panel_en_i, cpu_halt_n_i, tx_ready_i, rx_valid_i, slow;
    logic sw_tx_valid_i, sw_tx_ready_o, pnl_tx_valid_i, pnl_ack_o, prompt_req_i, run_cmd_i;
    logic disconnect_i, cpu_run_o, status_req_o, mode_console_o, panel_active_o, dtr_o;
    logic [3:0] baud_jmp_i, baud_sel_o;
    logic [7:0] rx_data_i, sw_tx_data_i, pnl_tx_data_i, d, q[3][$], f[$];
    cpm_pkg::cpm_byte_t tx_o, sw_rx_o, cmd_o;
    int miscompares, n_compared, cyc;
    cpm_console_port u_cpm_console_port (.*);
    cpm_term u_cpm_term (.clock_i(clock_i), .slow_i(slow), .ready_o(tx_ready_i),
        .key_valid_o(rx_valid_i), .key_data_o(rx_data_i));
    initial begin
        clock_i = 0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic conclude();
        `CHK("leftover", 0, q[0].size() + q[1].size() + q[2].size())
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic pop(input int s, input logic [7:0] v);
        logic [7:0] e;
        e = (q[s].size() == 0) ? ~v : q[s].pop_front();
        `CHK("stream byte", e, v)
    endtask
    // Each result takes the oldest note of its stream
    always @(posedge clock_i) if (rst_n_i) begin
        if (tx_o.valid && tx_ready_i) pop(0, tx_o.data);
        if (sw_rx_o.valid) pop(1, sw_rx_o.data);
        if (cmd_o.valid) pop(2, cmd_o.data);
        cyc++;
        if (cyc == 20000) begin miscompares++; conclude(); end
    end
    task automatic press(input logic [7:0] c, input int k);
        if (k != 1) q[2].push_back(c);
        if (k == 0) q[0].push_back(c);
        if (k == 1) q[1].push_back(c);
        u_cpm_term.key(c);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock_i) s = 1;
        @(negedge clock_i) s = 0;
        repeat (8) @(negedge clock_i);
    endtask
    task automatic drain();
        repeat (300) begin
            @(negedge clock_i);
            if (q[0].size() == 0) break;
        end
    endtask
    // Main sequence
    initial begin
        {rst_n_i, sw_tx_valid_i, pnl_tx_valid_i, prompt_req_i, run_cmd_i, disconnect_i} = '0;
        {sw_tx_data_i, pnl_tx_data_i, slow} = '0;
        {panel_en_i, cpu_halt_n_i} = 2'h3;
        void'($urandom(32));
        baud_jmp_i = 4'($urandom);
        q[0] = {8'h2F, 8'h2F};
        repeat (4) @(negedge clock_i);
        rst_n_i = 1;
        repeat (8) @(negedge clock_i);
        `CHK("baud", baud_jmp_i, baud_sel_o)
        `CHK("mode", 1'b0, mode_console_o)
        repeat (3) press(8'h41 + 8'($urandom % 10), 0);
        forever begin
            @(negedge clock_i);
            if (!sw_tx_ready_o) break;
            d = 8'($urandom);
            {sw_tx_valid_i, sw_tx_data_i} = {1'($urandom), d};
            if (sw_tx_valid_i) f.push_back(d);
        end
        sw_tx_valid_i = 0;
        `CHK("queued", 16, f.size())
        press(8'h40, 0);
        press(8'h40, 0);
        press(8'h43, 0);
        q[0] = {q[0], 8'h0D, 8'h0A, f};
        slow = 1;
        press(8'h0D, 2);
        `CHK("mode", 1'b1, mode_console_o)
        q[1] = {8'h40, 8'h40};
        prompt_req_i = 1'($urandom);
        u_cpm_term.key(8'h40);
        u_cpm_term.key(8'h40);
        press(8'h41, 1);
        q[0] = {q[0], 8'h0D, 8'h0A, 8'h2F, 8'h2F};
        u_cpm_term.key(8'h40);
        u_cpm_term.key(8'h40);
        u_cpm_term.key(8'h50);
        prompt_req_i = 0;
        u_cpm_term.key(8'h0D);
        drain();
        `CHK("mode", 1'b0, mode_console_o)
        pulse(run_cmd_i);
        `CHK("mode", 1'b1, mode_console_o)
        cpu_halt_n_i = 0;
        repeat (8) @(negedge clock_i);
        `CHK("mode", 1'b0, mode_console_o)
        d = 8'($urandom);
        q[0] = {q[0], d, 8'h2F, 8'h2F};
        {pnl_tx_valid_i, pnl_tx_data_i} = {1'b1, d};
        repeat (50) @(negedge clock_i) if (pnl_ack_o) break;
        pnl_tx_valid_i = 0;
        pulse(prompt_req_i);
        drain();
        pulse(run_cmd_i);
        `CHK("dtr", 1'b1, dtr_o)
        pulse(disconnect_i);
        `CHK("dtr", 1'b0, dtr_o)
        {rst_n_i, panel_en_i} = 2'h0;
        repeat (4) @(negedge clock_i);
        rst_n_i = 1;
        repeat (8) @(negedge clock_i);
        `CHK("panel", 1'b0, panel_active_o)
        press(8'h42, 1);
        {sw_tx_valid_i, sw_tx_data_i} = {1'b1, 8'h5A};
        q[0].push_back(8'h5A);
        @(negedge clock_i) sw_tx_valid_i = 0;
        drain();
        conclude();
    end
endmodule
